// >>> drc_bus_master.sv
// Two-wire bus master model that drives the regulator control slave.
`timescale 1ns/1ps
`default_nettype none
module drc_bus_master (
   output logic     scl_o,
   output logic     sda_low,
   input  wire logic sda_line
);
   // Half bit time in ns; 1250 gives the fast rate, 5000 the standard rate.
   int half = 1250;
   initial begin
      scl_o = 1'b1;
      sda_low = 1'b0;
   end
   task automatic set_half(input int h);
      half = h;
   endtask
   // The 7 ns offset keeps bus edges away from the system clock edges.
   task automatic start_cond();
      #7;
      #(half / 2) sda_low = 1'b0;
      #(half / 2) scl_o = 1'b1;
      #(half) sda_low = 1'b1;
      #(half) scl_o = 1'b0;
   endtask
   task automatic stop_cond();
      #(half / 2) sda_low = 1'b1;
      #(half / 2) scl_o = 1'b1;
      #(half) sda_low = 1'b0;
      #(half);
   endtask
   // Data moves only while the clock is low, so no false start is seen.
   task automatic bit_io(input logic b, output logic r);
      #(half / 2) sda_low = !b;
      #(half / 2) scl_o = 1'b1;
      #(half) r = sda_line;
      scl_o = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], a);
      end
      bit_io(1'b1, a);
      ack = !a;
   endtask
   task automatic wr(input logic [6:0] adr, input logic [7:0] ptr,
                     input logic [7:0] d, output logic ok);
      logic a;
      start_cond();
      wbyte({adr, 1'b0}, ok);
      if (ok) begin
         wbyte(ptr, a);
         ok = ok & a;
         wbyte(d, a);
         ok = ok & a;
      end
      stop_cond();
   endtask
   task automatic rd(input logic [6:0] adr, input logic [7:0] ptr,
                     output logic [7:0] q, output logic ok);
      logic a;
      q = 8'h00;
      start_cond();
      wbyte({adr, 1'b0}, ok);
      if (ok) begin
         wbyte(ptr, a);
         ok = ok & a;
         start_cond();
         wbyte({adr, 1'b1}, a);
         ok = ok & a;
         for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, q[i]);
         end
         bit_io(1'b1, a);
      end
      stop_cond();
   endtask
endmodule
`default_nettype wire

// >>> drc_cfg.svh
// Register offsets, field positions, reset values and timing figures.
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH
`define DRC_ADDR_GND     7'h60
`define DRC_ADDR_OPEN    7'h61
`define DRC_ADDR_HIGH    7'h62
`define DRC_STRAP_GND    2'h0
`define DRC_STRAP_OPEN   2'h1
`define DRC_STRAP_HIGH   2'h2
`define DRC_REG_VSEL1    8'h00
`define DRC_REG_VSEL2    8'h01
`define DRC_REG_CMD1     8'h02
`define DRC_REG_CMD2     8'h03
`define DRC_REG_STATUS   8'h04
`define DRC_RESET_VAL    8'h00
`define DRC_VSEL_MASK    8'hFF
`define DRC_CMD_MASK     8'h7F
`define DRC_GO_BIT       7
`define DRC_CODE_MSB     6
`define DRC_RAMP_MSB     6
`define DRC_RAMP_LSB     4
`define DRC_BLEED_BIT    3
`define DRC_LL_MSB       2
`define DRC_LL_LSB       1
`define DRC_OFF_BIT      0
`define DRC_STD_KBPS     100
`define DRC_FAST_KBPS    400
`define DRC_CLK_KHZ      10000
`define DRC_MIN_CLK_PER_BIT 8
`endif

// >>> drc_pkg.sv
// Types shared by the regulator control interface.
package drc_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } drc_state_t;

   typedef struct packed {
      logic [6:0] target_code;
      logic       go;
      logic       internal_divider;
      logic [2:0] ramp_code;
      logic [7:0] ramp_interval;
      logic       bleed_enable;
      logic [1:0] light_load_select;
      logic       channel_off;
   } drc_chan_t;

   typedef struct packed {
      drc_state_t      st;
      logic [3:0]      bitcnt;
      logic            rw;
      logic [7:0]      ptr;
      logic [7:0]      tx;
      logic            sda_oe;
      logic [6:0]      addr7;
      logic [1:0]      cap_cnt;
      logic            scl_s1;
      logic            scl_s2;
      logic            scl_d;
      logic            sda_s1;
      logic            sda_s2;
      logic            sda_d;
      logic [1:0]      en_s1;
      logic [1:0]      en_s2;
      logic [2:0]      flg_s1;
      logic [2:0]      flg_s2;
      logic [1:0]      strap_s1;
      logic [1:0]      strap_s2;
      logic [1:0][7:0] vsel;
      logic [1:0][7:0] cmd;
   } drc_core_t;
endpackage

// >>> drc_regulator_ctrl.sv
// Two-wire slave and register bank for a dual step-down regulator.
`timescale 1ns/1ps
`default_nettype none
`include "drc_cfg.svh"

// What this block does
// - Slave only, same protocol at both rates.
// - Seven-bit address only, no general call.
// - Strap low gives address 0x60.
// - Strap open gives 0x61, high gives 0x62.
// - Acknowledge low during ninth clock high.
// - Commit on falling edge after data LSB.
// - Both enables low blocks bus updates.
// - Go bit enables serial voltage control.
// - Seven-bit target code, 10 mV steps.
// - Ramp code n steps every 2^n cycles.
// - Command bit 3 enables soft discharge.
// - Two bits select light-load behaviour.
// - Bit 0 forces output off; bit 7 reserved.
// - Status bit 2 shows die over-temperature.
// - Status bits 1,0 show out-of-window.
// - Go set switches to internal divider.
// - Without go, external divider sets output.
module drc_regulator_ctrl #(
   parameter int CLK_KHZ = `DRC_CLK_KHZ
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             scl_clk,
   input  wire logic             scl_i,
   input  wire logic             sda_i,
   output logic                  sda_o,
   output logic                  sda_oe,
   input  wire logic [1:0]       strap_code,
   input  wire logic             channel1_enable_pin,
   input  wire logic             channel2_enable_pin,
   input  wire logic             die_hot,
   input  wire logic             channel1_out_of_window,
   input  wire logic             channel2_out_of_window,
   output wire drc_pkg::drc_chan_t chan1_ctrl,
   output wire drc_pkg::drc_chan_t chan2_ctrl
);

   // Fast mode needs enough clk cycles per bit to absorb sync delay.
   if (CLK_KHZ / `DRC_FAST_KBPS < `DRC_MIN_CLK_PER_BIT) begin : g_chk
      $error("Clock too slow for fast-mode bus");
   end

   drc_pkg::drc_core_t s_r;
   drc_pkg::drc_core_t s_nxt;
   logic [7:0]         link_shift_r;
   logic               scl_rise;
   logic               scl_fall;
   logic               bus_start;
   logic               bus_stop;
   logic               shutdown;
   logic               addr_hit;

   function automatic logic [6:0] strap_addr(input logic [1:0] code);
      if (code == `DRC_STRAP_OPEN) begin
         strap_addr = `DRC_ADDR_OPEN;
      end else if (code == `DRC_STRAP_HIGH) begin
         strap_addr = `DRC_ADDR_HIGH;
      end else begin
         strap_addr = `DRC_ADDR_GND;
      end
   endfunction

   function automatic logic [7:0] read_reg(input logic [7:0] a,
                                           input drc_pkg::drc_core_t c);
      if (a == `DRC_REG_VSEL1) begin
         read_reg = c.vsel[0];
      end else if (a == `DRC_REG_VSEL2) begin
         read_reg = c.vsel[1];
      end else if (a == `DRC_REG_CMD1) begin
         read_reg = c.cmd[0] & `DRC_CMD_MASK;
      end else if (a == `DRC_REG_CMD2) begin
         read_reg = c.cmd[1] & `DRC_CMD_MASK;
      end else if (a == `DRC_REG_STATUS) begin
         read_reg = {5'h00, c.flg_s2};
      end else begin
         read_reg = 8'h00;
      end
   endfunction

   function automatic logic [7:0] ramp_cycles(input logic [2:0] code);
      ramp_cycles = 8'h01 << code;
   endfunction

   function automatic drc_pkg::drc_chan_t chan_view(input logic [7:0] v,
                                                    input logic [7:0] c);
      chan_view.target_code       = v[`DRC_CODE_MSB:0];
      chan_view.go                = v[`DRC_GO_BIT];
      chan_view.internal_divider  = v[`DRC_GO_BIT];
      chan_view.ramp_code         = c[`DRC_RAMP_MSB:`DRC_RAMP_LSB];
      chan_view.ramp_interval     =
         ramp_cycles(c[`DRC_RAMP_MSB:`DRC_RAMP_LSB]);
      chan_view.bleed_enable      = c[`DRC_BLEED_BIT];
      chan_view.light_load_select = c[`DRC_LL_MSB:`DRC_LL_LSB];
      chan_view.channel_off       = c[`DRC_OFF_BIT];
   endfunction

   // Link side: bits are taken on the rising bus clock. The shift
   // register is pure data; the clk side reads it only after seeing
   // the synchronised rise, and it holds for the rest of the bit.
   always_ff @(posedge scl_clk) begin
      link_shift_r <= {link_shift_r[6:0], sda_i};
   end

   assign scl_rise  = s_r.scl_s2 & ~s_r.scl_d;
   assign scl_fall  = ~s_r.scl_s2 & s_r.scl_d;
   assign bus_start = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
   assign bus_stop  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
   assign shutdown  = ~s_r.en_s2[0] & ~s_r.en_s2[1];
   assign addr_hit  = (link_shift_r[7:1] == s_r.addr7) &&
                      (s_r.cap_cnt == 2'h3) && !shutdown;

   always_comb begin
      s_nxt          = s_r;
      s_nxt.scl_s1   = scl_i;
      s_nxt.scl_s2   = s_r.scl_s1;
      s_nxt.scl_d    = s_r.scl_s2;
      s_nxt.sda_s1   = sda_i;
      s_nxt.sda_s2   = s_r.sda_s1;
      s_nxt.sda_d    = s_r.sda_s2;
      s_nxt.en_s1    = {channel2_enable_pin, channel1_enable_pin};
      s_nxt.en_s2    = s_r.en_s1;
      s_nxt.flg_s1   = {die_hot, channel2_out_of_window,
                        channel1_out_of_window};
      s_nxt.flg_s2   = s_r.flg_s1;
      s_nxt.strap_s1 = strap_code;
      s_nxt.strap_s2 = s_r.strap_s1;
      // The strap is read once, after its synchroniser has settled.
      if (s_r.cap_cnt != 2'h3) begin
         s_nxt.cap_cnt = s_r.cap_cnt + 2'h1;
      end
      if (s_r.cap_cnt == 2'h2) begin
         s_nxt.addr7 = strap_addr(s_r.strap_s2);
      end
      if (scl_rise) begin
         s_nxt.bitcnt = s_r.bitcnt + 4'h1;
      end
      // Start and stop are decoded the same way at either rate.
      if (bus_start) begin
         s_nxt.st     = drc_pkg::ST_ADDR;
         s_nxt.bitcnt = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (bus_stop) begin
         s_nxt.st     = drc_pkg::ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else begin
         case (s_r.st)
            drc_pkg::ST_ADDR: begin
               if (scl_rise && s_r.bitcnt == 4'h7) begin
                  s_nxt.rw = link_shift_r[0];
                  s_nxt.st = addr_hit ? drc_pkg::ST_ADDR_ACK
                                      : drc_pkg::ST_IDLE;
               end
            end
            drc_pkg::ST_ADDR_ACK: begin
               if (scl_fall && !s_r.sda_oe) begin
                  s_nxt.sda_oe = 1'b1;
               end else if (scl_fall) begin
                  s_nxt.bitcnt = 4'h0;
                  if (s_r.rw) begin
                     s_nxt.tx     = read_reg(s_r.ptr, s_r);
                     s_nxt.sda_oe = ~s_nxt.tx[7];
                     s_nxt.st     = drc_pkg::ST_RDATA;
                  end else begin
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.st     = drc_pkg::ST_REG;
                  end
               end
            end
            drc_pkg::ST_REG: begin
               if (scl_rise && s_r.bitcnt == 4'h7) begin
                  s_nxt.ptr = link_shift_r;
                  s_nxt.st  = drc_pkg::ST_REG_ACK;
               end
            end
            drc_pkg::ST_REG_ACK: begin
               if (scl_fall && !s_r.sda_oe) begin
                  s_nxt.sda_oe = 1'b1;
               end else if (scl_fall) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.st     = drc_pkg::ST_WDATA;
               end
            end
            drc_pkg::ST_WDATA: begin
               if (scl_rise && s_r.bitcnt == 4'h7) begin
                  s_nxt.st = drc_pkg::ST_WDATA_ACK;
               end
            end
            drc_pkg::ST_WDATA_ACK: begin
               if (scl_fall && !s_r.sda_oe) begin
                  s_nxt.sda_oe = 1'b1;
                  // The falling edge after the last data bit commits.
                  if (!shutdown) begin
                     if (s_r.ptr == `DRC_REG_VSEL1) begin
                        s_nxt.vsel[0] = link_shift_r & `DRC_VSEL_MASK;
                     end else if (s_r.ptr == `DRC_REG_VSEL2) begin
                        s_nxt.vsel[1] = link_shift_r & `DRC_VSEL_MASK;
                     end else if (s_r.ptr == `DRC_REG_CMD1) begin
                        s_nxt.cmd[0] = link_shift_r & `DRC_CMD_MASK;
                     end else if (s_r.ptr == `DRC_REG_CMD2) begin
                        s_nxt.cmd[1] = link_shift_r & `DRC_CMD_MASK;
                     end
                  end
               end else if (scl_fall) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.ptr    = s_r.ptr + 8'h01;
                  s_nxt.st     = drc_pkg::ST_WDATA;
               end
            end
            drc_pkg::ST_RDATA: begin
               if (scl_fall && s_r.bitcnt == 4'h8) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st     = drc_pkg::ST_RDATA_ACK;
               end else if (scl_fall) begin
                  s_nxt.tx     = {s_r.tx[6:0], 1'b0};
                  s_nxt.sda_oe = ~s_r.tx[6];
               end
            end
            drc_pkg::ST_RDATA_ACK: begin
               // A high ninth bit is the master's not-acknowledge.
               if (scl_rise) begin
                  if (link_shift_r[0]) begin
                     s_nxt.st = drc_pkg::ST_IDLE;
                  end else begin
                     s_nxt.ptr = s_r.ptr + 8'h01;
                  end
               end else if (scl_fall && s_r.bitcnt == 4'h9) begin
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.tx     = read_reg(s_r.ptr, s_r);
                  s_nxt.sda_oe = ~s_nxt.tx[7];
                  s_nxt.st     = drc_pkg::ST_RDATA;
               end
            end
            default: begin
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      // Reset clears the edge detectors, so one false rise may follow;
      // it is harmless because the idle state ignores the bit count.
      if (!reset_n) begin
         s_nxt         = '0;
         s_nxt.st      = drc_pkg::ST_IDLE;
         s_nxt.vsel[0] = `DRC_RESET_VAL;
         s_nxt.vsel[1] = `DRC_RESET_VAL;
         s_nxt.cmd[0]  = `DRC_RESET_VAL;
         s_nxt.cmd[1]  = `DRC_RESET_VAL;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   // Open drain: the pin is only ever pulled low.
   assign sda_o      = 1'b0;
   assign sda_oe     = s_r.sda_oe;
   assign chan1_ctrl = chan_view(s_r.vsel[0], s_r.cmd[0]);
   assign chan2_ctrl = chan_view(s_r.vsel[1], s_r.cmd[1]);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_ack_begin;
      scl_fall && !s_r.sda_oe && !bus_start && !bus_stop &&
      (s_r.st inside {drc_pkg::ST_ADDR_ACK, drc_pkg::ST_REG_ACK,
                      drc_pkg::ST_WDATA_ACK});
   endsequence

   sequence s_commit_vsel1;
      s_ack_begin and (s_r.st == drc_pkg::ST_WDATA_ACK) &&
      (s_r.ptr == `DRC_REG_VSEL1) && !shutdown;
   endsequence

   a_ack_pull_low: assert property (
      s_ack_begin |=> s_r.sda_oe && s_r.st == $past(s_r.st))
      else $error("Acknowledge not driven at falling edge");

   a_ack_held_high: assert property (
      s_ack_begin ##1 (!scl_fall && !bus_start && !bus_stop)[*3]
      |-> s_r.sda_oe)
      else $error("Acknowledge released too early");

   a_commit_lsb: assert property (
      s_commit_vsel1 |=> s_r.vsel[0] == $past(link_shift_r))
      else $error("Write not committed on LSB falling edge");

   a_shutdown_block: assert property (
      shutdown && s_r.st == drc_pkg::ST_ADDR && scl_rise &&
      s_r.bitcnt == 4'h7 && !bus_start && !bus_stop
      |=> s_r.st == drc_pkg::ST_IDLE)
      else $error("Address acknowledged in hardware shutdown");

   a_addr_mismatch: assert property (
      s_r.st == drc_pkg::ST_ADDR && scl_rise && s_r.bitcnt == 4'h7 &&
      link_shift_r[7:1] != s_r.addr7 && !bus_start && !bus_stop
      |=> s_r.st == drc_pkg::ST_IDLE)
      else $error("Foreign address accepted");

   a_strap_map: assert property (
      s_r.cap_cnt == 2'h2 |=> s_r.addr7 ==
         (($past(s_r.strap_s2) == `DRC_STRAP_OPEN) ? `DRC_ADDR_OPEN :
          ($past(s_r.strap_s2) == `DRC_STRAP_HIGH) ? `DRC_ADDR_HIGH :
          `DRC_ADDR_GND))
      else $error("Strap decoded to wrong slave address");

   a_read_first_bit: assert property (
      s_r.st != drc_pkg::ST_RDATA ##1 s_r.st == drc_pkg::ST_RDATA
      |-> s_r.sda_oe == ~s_r.tx[7] && s_r.bitcnt == 4'h0)
      else $error("First read bit not presented");

   a_status_bits: assert property (
      read_reg(`DRC_REG_STATUS, s_r) == {5'h00, $past(s_r.flg_s1)})
      else $error("Status register does not follow the flags");

   a_reserved_zero: assert property (
      s_r.cmd[0][7] == 1'b0 && s_r.cmd[1][7] == 1'b0)
      else $error("Reserved command bit became set");

   a_go_divider: assert property (
      s_commit_vsel1 ##1 s_r.vsel[0][`DRC_GO_BIT]
      |-> chan1_ctrl.internal_divider &&
          {1'b1, chan1_ctrl.target_code} == $past(link_shift_r))
      else $error("Go flag did not select internal divider");

   a_ack_release: assert property (
      scl_fall && s_r.sda_oe && !bus_start && !bus_stop &&
      (s_r.st inside {drc_pkg::ST_REG_ACK, drc_pkg::ST_WDATA_ACK})
      |=> !s_r.sda_oe)
      else $error("Acknowledge held past its clock pulse");

   a_nack_ends_read: assert property (
      s_r.st == drc_pkg::ST_RDATA_ACK && scl_rise && link_shift_r[0] &&
      !bus_start && !bus_stop |=> s_r.st == drc_pkg::ST_IDLE)
      else $error("Read went on after not-acknowledge");

endmodule
`default_nettype wire

// >>> drc_regulator_ctrl_tb_top.sv
// Self-checking bench for the regulator control block.
`timescale 1ns/1ps
`default_nettype none
`include "drc_cfg.svh"
module drc_regulator_ctrl_tb_top;
   logic               clk;
   logic               reset_n;
   logic [1:0]         strap_code;
   logic               chan1_enable;
   logic               chan2_enable;
   logic               hot;
   logic               oow1;
   logic               oow2;
   logic               scl;
   logic               m_low;
   logic               dut_sda_o;
   logic               dut_sda_oe;
   wire                sda_w;
   wire drc_pkg::drc_chan_t ch1;
   wire drc_pkg::drc_chan_t ch2;
   int                 mismatches;
   int                 total_checks;
   logic [7:0]         rdat;
   logic [7:0]         cv;
   logic               ok;
   logic [6:0]         adr;
   // Open-drain wire with pull-up: low if either party pulls it.
   assign sda_w = !(m_low || (dut_sda_oe && !dut_sda_o));
   drc_regulator_ctrl dut_u (
      .clk                    (clk),
      .reset_n                (reset_n),
      .scl_clk                (scl),
      .scl_i                  (scl),
      .sda_i                  (sda_w),
      .sda_o                  (dut_sda_o),
      .sda_oe                 (dut_sda_oe),
      .strap_code             (strap_code),
      .channel1_enable_pin    (chan1_enable),
      .channel2_enable_pin    (chan2_enable),
      .die_hot                (hot),
      .channel1_out_of_window (oow1),
      .channel2_out_of_window (oow2),
      .chan1_ctrl             (ch1),
      .chan2_ctrl             (ch2)
   );
   drc_bus_master master_u (
      .scl_o    (scl),
      .sda_low  (m_low),
      .sda_line (sda_w)
   );
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic print_verdict();
      if (mismatches == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [23:0] e,
                      input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic drc_pkg::drc_chan_t mk(input logic [7:0] v,
                                             input logic [7:0] c);
      mk = '0;
      mk.target_code = v[6:0];
      mk.go = v[7];
      mk.internal_divider = v[7];
      mk.ramp_code = c[6:4];
      mk.ramp_interval = 8'h01 << c[6:4];
      mk.bleed_enable = c[3];
      mk.light_load_select = c[2:1];
      mk.channel_off = c[0];
   endfunction
   function automatic logic [6:0] adr_of(input logic [1:0] s);
      adr_of = (s == `DRC_STRAP_OPEN) ? `DRC_ADDR_OPEN :
               (s == `DRC_STRAP_HIGH) ? `DRC_ADDR_HIGH : `DRC_ADDR_GND;
   endfunction
   task automatic wr(input logic [7:0] p, input logic [7:0] d,
                     input logic e);
      master_u.wr(adr, p, d, ok);
      chk("write ack", {23'h000000, e}, {23'h000000, ok});
   endtask
   task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
      master_u.rd(adr, p, rdat, ok);
      chk("read ack", 24'h000001, {23'h000000, ok});
      chk("read data", {16'h0000, e}, {16'h0000, rdat});
   endtask
   task automatic do_reset(input logic [1:0] s);
      @(posedge clk);
      reset_n <= 1'b0;
      strap_code <= s;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   initial begin
      reset_n = 1'b0;
      strap_code = 2'h0;
      chan1_enable = 1'b1;
      chan2_enable = 1'b1;
      hot = 1'b0;
      oow1 = 1'b0;
      oow2 = 1'b0;
      mismatches = 0;
      total_checks = 0;
      for (int s = 0; s < 3; s++) begin
         do_reset(s[1:0]);
         adr = adr_of(s[1:0]);
         chk("chan1 reset", mk(8'h00, 8'h00), ch1);
         chk("chan2 reset", mk(8'h00, 8'h00), ch2);
         for (int r = 0; r < 5; r++) begin
            rd_chk(r[7:0], 8'h00);
         end
         wr(`DRC_REG_VSEL1, 8'h85, 1'b1);
         adr = adr_of(s[1:0]) ^ 7'h03;
         wr(`DRC_REG_VSEL1, 8'h11, 1'b0);
         adr = 7'h00;
         wr(`DRC_REG_VSEL1, 8'h11, 1'b0);
         adr = 7'h78;
         wr(`DRC_REG_VSEL1, 8'h11, 1'b0);
         adr = adr_of(s[1:0]);
         rd_chk(`DRC_REG_VSEL1, 8'h85);
      end
      wr(`DRC_REG_VSEL1, 8'hFF, 1'b1);
      wr(`DRC_REG_VSEL2, 8'h7F, 1'b1);
      for (int n = 0; n < 8; n++) begin
         cv = {1'b1, n[2:0], n[0], n[1:0], n[2]};
         wr(`DRC_REG_CMD1, cv, 1'b1);
         wr(`DRC_REG_CMD2, ~cv, 1'b1);
         chk("chan1", mk(8'hFF, cv), ch1);
         chk("chan2", mk(8'h7F, ~cv), ch2);
         rd_chk(`DRC_REG_CMD1, cv & `DRC_CMD_MASK);
      end
      for (int s = 0; s < 8; s++) begin
         @(posedge clk);
         {hot, oow2, oow1} <= s[2:0];
         repeat (4) @(posedge clk);
         rd_chk(`DRC_REG_STATUS, {5'h00, s[2:0]});
      end
      wr(8'h05, 8'hAA, 1'b1);
      rd_chk(8'h05, 8'h00);
      @(posedge clk);
      chan1_enable <= 1'b0;
      chan2_enable <= 1'b0;
      repeat (4) @(posedge clk);
      wr(`DRC_REG_VSEL1, 8'h12, 1'b0);
      chk("chan1 shutdown", mk(8'hFF, 8'hFF), ch1);
      @(posedge clk);
      chan1_enable <= 1'b1;
      repeat (4) @(posedge clk);
      wr(`DRC_REG_VSEL1, 8'h12, 1'b1);
      rd_chk(`DRC_REG_VSEL1, 8'h12);
      master_u.set_half(5000);
      wr(`DRC_REG_VSEL2, 8'hA5, 1'b1);
      rd_chk(`DRC_REG_VSEL2, 8'hA5);
      chk("chan2 slow", mk(8'hA5, 8'h00), ch2);
      print_verdict();
   end
endmodule
`default_nettype wire
